// ===== hw/ise_pkg.sv
package ise_pkg;

    // ****************************************
    // Array geometry
    // ****************************************
    localparam int ADDR_W = 10;
    localparam int ARRAY_BYTES = 1024;
    localparam int PAGE_W = 6;
    localparam int PAGE_OFS_W = 4;
    localparam int PAGE_BYTES = 16;
    localparam int BYTE_W = 8;
    localparam logic [9:0] ADDR_RESET = 10'h000;

    // ****************************************
    // Device address word layout
    // ****************************************
    localparam logic [3:0] DEV_PREAMBLE = 4'ha;
    localparam int DEV_PRE_LSB = 4;
    localparam int DEV_STRAP_BIT = 3;
    localparam int DEV_HI_LSB = 1;
    localparam int DEV_DIR_BIT = 0;

    // ****************************************
    // Bit framing and buffering
    // ****************************************
    localparam int BIT_CNT_W = 4;
    localparam logic [3:0] BITS_PER_WORD = 4'h8;
    localparam int SYNC_W = 4;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_W = PAGE_OFS_W + BYTE_W;

    // ****************************************
    // Program cycle timing
    // ****************************************
    localparam int CLK_FREQ_KHZ = 25000;
    localparam int PROG_TIME_MS = 3;
    localparam int PROG_CYCLES = PROG_TIME_MS * CLK_FREQ_KHZ;
    localparam int PROG_CNT_W = 17;

    typedef enum logic [2:0] {
        sIdle, sDev, sWord, sData, sAck, sRead, sRack
    } ise_link_t;

    typedef enum logic [2:0] {
        pIdle, pDrain, pCommit, pHold, pClear
    } ise_prog_t;

endpackage

// ===== hw/ise_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ise_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1Reg;

    // ****************************************
    // Two-flop synchroniser
    // ****************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            stage1Reg <= '0;
            syncOut <= '0;
        end else begin
            stage1Reg <= asyncIn;
            syncOut <= stage1Reg;
        end
    end
endmodule
`default_nettype wire

// ===== hw/ise_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module ise_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [PW-1:0] wrPtrReg;
    logic [PW-1:0] rdPtrReg;
    logic [PW:0] countReg;
    logic doWrite;
    logic doRead;

    // ****************************************
    // Honest full and empty
    // ****************************************
    assign inReady = (countReg != (PW+1)'(DEPTH));
    assign outValid = (countReg != '0);
    assign outData = store[rdPtrReg];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    always_ff @(posedge clk) begin
        if (doWrite) begin
            store[wrPtrReg] <= inData;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtrReg <= '0;
            rdPtrReg <= '0;
            countReg <= '0;
        end else begin
            if (doWrite) begin
                wrPtrReg <= wrPtrReg + 1'b1;
            end
            if (doRead) begin
                rdPtrReg <= rdPtrReg + 1'b1;
            end
            countReg <= countReg + (PW+1)'(doWrite) - (PW+1)'(doRead);
        end
    end
endmodule
`default_nettype wire

// ===== hw/ise_target.sv
// Summary of operation
// - 1024 bytes, 64 pages of 16, 10-bit address
// - Data changes with clock high mean start/stop
// - Data fall with clock high starts address reception
// - Stop after read returns to standby
// - Sample on clock rise, drive after fall
// - Acknowledge low in ninth clock of each word
// - Standby at reset and after stop plus program
// - Device word after start, preamble must match
// - Strap bit compared with strap pin level
// - Direction bit one reads, zero writes
// - Match acknowledges, mismatch no acknowledge, standby
// - Write-inhibit pin high protects whole array
// - Byte write: word address, one byte, stop
// - Program cycle after stop, inputs ignored meanwhile
// - Page write up to sixteen bytes then stop
// - Writes increment low four bits, page wraps
// - Polling acknowledged only after program cycle ends
// - Counter holds last address plus one
// - Current read sends byte at counter
// - Acknowledged read increments counter, wraps array
`timescale 1ns/10ps
`default_nettype none
module ise_target import ise_pkg::*; #(
    parameter int unsigned PROG_COUNT = PROG_CYCLES
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaDriveN,
    input wire logic writeInhibit,
    input wire logic chip_select_strap,
    output logic standbyReg,
    output logic progBusyReg
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [SYNC_W-1:0] pinsSync;
    logic sclS;
    logic sdaS;
    logic wpS;
    logic strapS;
    logic sclDReg;
    logic sdaDReg;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    ise_link_t state;
    ise_link_t ackNext;
    logic [BIT_CNT_W-1:0] bitCnt;
    logic [BYTE_W-1:0] rxShift;
    logic [BYTE_W-1:0] txShift;
    logic [1:0] addrHi;
    logic [ADDR_W-1:0] addrCnt;
    logic [PAGE_W-1:0] progPage;
    logic pushPend;
    logic [FIFO_W-1:0] pushData;
    logic wroteData;
    logic progReq;
    logic progKeep;
    logic devMatch;
    ise_prog_t pState;
    logic keepReg;
    logic [PAGE_OFS_W-1:0] commitIdx;
    logic [PROG_CNT_W-1:0] holdCnt;
    logic busy;
    logic fifoInReady;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [FIFO_W-1:0] fifoOutData;
    logic [BYTE_W-1:0] mem [ARRAY_BYTES];
    logic [BYTE_W-1:0] pageData [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] pageValid;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    ise_sync #(
        .WIDTH(SYNC_W)
    ) pinSync (
        .clk(core_clk),
        .rst(srst),
        // Line pins cross inverted so the flops reset to the idle high level
        .asyncIn({~scl, ~sdaIn, writeInhibit, chip_select_strap}),
        .syncOut(pinsSync)
    );

    assign sclS = !pinsSync[3];
    assign sdaS = !pinsSync[2];
    assign wpS = pinsSync[1];
    // Pin reads low when left floating, handled by the pad pull-down
    assign strapS = pinsSync[0];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclDReg <= 1'b1;
            sdaDReg <= 1'b1;
        end else begin
            sclDReg <= sclS;
            sdaDReg <= sdaS;
        end
    end

    assign sclRise = sclS && !sclDReg;
    assign sclFall = !sclS && sclDReg;
    // Clock high on both samples, so a data edge is a condition
    assign startSeen = sclS && sclDReg && sdaDReg && !sdaS;
    assign stopSeen = sclS && sclDReg && !sdaDReg && sdaS;

    assign busy = (pState != pIdle);
    assign devMatch = (rxShift[7:DEV_PRE_LSB] == DEV_PREAMBLE)
        && (rxShift[DEV_STRAP_BIT] == strapS)
        && !busy;

    // ****************************************
    // Link protocol engine
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= sIdle;
            ackNext <= sIdle;
            bitCnt <= '0;
            rxShift <= '0;
            txShift <= '0;
            addrHi <= '0;
            addrCnt <= ADDR_RESET;
            progPage <= '0;
            sdaDriveN <= 1'b1;
            pushPend <= 1'b0;
            pushData <= '0;
            wroteData <= 1'b0;
            progReq <= 1'b0;
            progKeep <= 1'b0;
        end else begin
            progReq <= 1'b0;
            // Back-pressure: byte waits here until the FIFO takes it
            if (pushPend && fifoInReady) begin
                pushPend <= 1'b0;
            end
            if (startSeen) begin
                state <= sDev;
                bitCnt <= '0;
                sdaDriveN <= 1'b1;
                // Write broken by a repeated start is discarded
                if (wroteData) begin
                    progReq <= 1'b1;
                    progKeep <= 1'b0;
                end
                wroteData <= 1'b0;
            end else if (stopSeen) begin
                state <= sIdle;
                sdaDriveN <= 1'b1;
                if (wroteData) begin
                    progReq <= 1'b1;
                    progKeep <= !wpS;
                end
                wroteData <= 1'b0;
            end else begin
                unique case (state)
                    sIdle: begin
                        sdaDriveN <= 1'b1;
                    end
                    sDev, sWord, sData: begin
                        if (sclRise) begin
                            rxShift <= {rxShift[BYTE_W-2:0], sdaS};
                            bitCnt <= bitCnt + 1'b1;
                        end else if (sclFall && bitCnt == BITS_PER_WORD) begin
                            bitCnt <= '0;
                            if (state == sDev) begin
                                if (devMatch) begin
                                    sdaDriveN <= 1'b0;
                                    state <= sAck;
                                    if (rxShift[DEV_DIR_BIT]) begin
                                        ackNext <= sRead;
                                        txShift <= mem[addrCnt];
                                        addrCnt <= addrCnt + 1'b1;
                                    end else begin
                                        ackNext <= sWord;
                                        addrHi <= rxShift[DEV_HI_LSB+:2];
                                    end
                                end else begin
                                    state <= sIdle;
                                end
                            end else if (state == sWord) begin
                                addrCnt <= {addrHi, rxShift};
                                progPage <= {addrHi, rxShift[7:PAGE_OFS_W]};
                                sdaDriveN <= 1'b0;
                                state <= sAck;
                                ackNext <= sData;
                            end else begin
                                pushData <= {addrCnt[PAGE_OFS_W-1:0], rxShift};
                                pushPend <= 1'b1;
                                wroteData <= 1'b1;
                                // Only the page offset advances
                                addrCnt[PAGE_OFS_W-1:0] <= addrCnt[PAGE_OFS_W-1:0] + 1'b1;
                                sdaDriveN <= 1'b0;
                                state <= sAck;
                                ackNext <= sData;
                            end
                        end
                    end
                    sAck: begin
                        if (sclFall) begin
                            bitCnt <= '0;
                            state <= ackNext;
                            // Leaving ack straight into the first read bit
                            sdaDriveN <= (ackNext == sRead) ? txShift[7] : 1'b1;
                        end
                    end
                    sRead: begin
                        if (sclRise) begin
                            bitCnt <= bitCnt + 1'b1;
                            txShift <= {txShift[BYTE_W-2:0], 1'b0};
                        end else if (sclFall) begin
                            if (bitCnt == BITS_PER_WORD) begin
                                sdaDriveN <= 1'b1;
                                bitCnt <= '0;
                                state <= sRack;
                            end else begin
                                sdaDriveN <= txShift[7];
                            end
                        end
                    end
                    sRack: begin
                        if (sclRise) begin
                            if (!sdaS) begin
                                txShift <= mem[addrCnt];
                                addrCnt <= addrCnt + 1'b1;
                                ackNext <= sRead;
                                state <= sAck;
                            end else begin
                                state <= sIdle;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Write byte buffer
    // ****************************************
    ise_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) byteFifo (
        .clk(core_clk),
        .rst(srst),
        .inValid(pushPend),
        .inReady(fifoInReady),
        .inData(pushData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // Latch stalls while the page is being committed
    assign fifoOutReady = (pState == pIdle) || (pState == pDrain);

    // ****************************************
    // Page latch
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (fifoOutValid && fifoOutReady) begin
            pageData[fifoOutData[FIFO_W-1:BYTE_W]] <= fifoOutData[BYTE_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pageValid <= '0;
        end else if (pState == pClear) begin
            pageValid <= '0;
        end else if (fifoOutValid && fifoOutReady) begin
            pageValid[fifoOutData[FIFO_W-1:BYTE_W]] <= 1'b1;
        end
    end

    // ****************************************
    // Self-timed program cycle
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pState <= pIdle;
            keepReg <= 1'b0;
            commitIdx <= '0;
            holdCnt <= '0;
        end else begin
            unique case (pState)
                pIdle: begin
                    if (progReq) begin
                        pState <= pDrain;
                        keepReg <= progKeep;
                    end
                end
                pDrain: begin
                    if (!fifoOutValid && !pushPend) begin
                        commitIdx <= '0;
                        pState <= keepReg ? pCommit : pClear;
                    end
                end
                pCommit: begin
                    commitIdx <= commitIdx + 1'b1;
                    if (commitIdx == PAGE_OFS_W'(PAGE_BYTES - 1)) begin
                        holdCnt <= '0;
                        pState <= pHold;
                    end
                end
                pHold: begin
                    // Full worst-case time, so polling never ends early
                    holdCnt <= holdCnt + 1'b1;
                    if (holdCnt == PROG_CNT_W'(PROG_COUNT - 1)) begin
                        pState <= pClear;
                    end
                end
                pClear: begin
                    pState <= pIdle;
                end
            endcase
        end
    end

    // Array itself is never reset: it models retained contents
    always_ff @(posedge core_clk) begin
        if (pState == pCommit && pageValid[commitIdx]) begin
            mem[{progPage, commitIdx}] <= pageData[commitIdx];
        end
    end

    // ****************************************
    // Status outputs
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sdaOut <= 1'b0;
            standbyReg <= 1'b1;
            progBusyReg <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
            standbyReg <= (state == sIdle) && !busy;
            progBusyReg <= busy;
        end
    end
endmodule
`default_nettype wire

// ===== tb/ise_target_chk.sv
`timescale 1ns/10ps
`default_nettype none
module ise_target_chk #(
    parameter int unsigned PROG_COUNT = 50
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic scl,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaDriveN,
    input wire logic writeInhibit,
    input wire logic chip_select_strap,
    input wire logic standbyReg,
    input wire logic progBusyReg
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // ****************************************
    // Busy length counter
    // ****************************************
    logic [19:0] busyCnt;
    always_ff @(posedge core_clk) begin
        if (srst || !progBusyReg) begin
            busyCnt <= 20'h00000;
        end else begin
            busyCnt <= busyCnt + 20'h00001;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    reset_idle_a: assert property ($fell(srst) |-> sdaDriveN && standbyReg && !progBusyReg)
        else $error("outputs not idle after reset");
    busy_idle_a: assert property (progBusyReg |-> !standbyReg)
        else $error("standby during program cycle");
    busy_quiet_a: assert property (progBusyReg |-> sdaDriveN)
        else $error("data line driven during program cycle");
    open_drain_a: assert property (!sdaDriveN |-> !sdaOut)
        else $error("driven level is not low");
    // Sync delay puts every change well inside the low phase
    drive_edge_a: assert property ($changed(sdaDriveN) |-> !scl && !$past(scl))
        else $error("data output changed while clock high");
    drive_hold_a: assert property ($fell(sdaDriveN) |-> !sdaDriveN [*6])
        else $error("driven low bit too short");
    busy_bound_a: assert property (progBusyReg |-> busyCnt < PROG_COUNT + 64)
        else $error("program cycle too long");
    prog_full_a: assert property ($fell(progBusyReg) && !writeInhibit |-> busyCnt >= PROG_COUNT)
        else $error("program cycle cut short");
    cover property ($rose(progBusyReg));
    cover property ($fell(sdaDriveN));
    cover property ($fell(standbyReg));
endmodule
`default_nettype wire

// ===== tb/ise_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module ise_ctrl_model (
    input wire logic core_clk,
    input wire logic sdaWire,
    output logic scl,
    output logic sdaCtl
);
    // ****************************************
    // Bus controller, open drain, pulled up
    // ****************************************
    int slowLow = 0;
    initial begin
        scl = 1'b1;
        sdaCtl = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Clock stands high between frames; extra low time models a slow side
    task automatic bit_io(input logic b, output logic r);
        scl = 1'b0;
        tick(3 + slowLow);
        sdaCtl = b;
        tick(1);
        scl = 1'b1;
        tick(3);
        r = sdaWire;
        tick(1);
    endtask
    task automatic start_cond();
        scl = 1'b0;
        tick(3);
        sdaCtl = 1'b1;
        tick(1);
        scl = 1'b1;
        tick(4);
        sdaCtl = 1'b0;
        tick(4);
    endtask
    task automatic stop_cond();
        scl = 1'b0;
        tick(3);
        sdaCtl = 1'b0;
        tick(1);
        scl = 1'b1;
        tick(4);
        sdaCtl = 1'b1;
        tick(4);
    endtask
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    task automatic get_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~more, r);
    endtask
    // Nine pulses with data released free a stuck target; first eight catch its bits
    task automatic recover(output logic [7:0] d);
        logic r;
        for (int i = 8; i >= 0; i--) begin
            bit_io(1'b1, r);
            if (i > 0) d[i-1] = r;
        end
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_ise_target.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ise_target;
    import ise_pkg::*;
    // ****************************************
    // Harness
    // ****************************************
    localparam int unsigned PROG_N = 200;
    logic core_clk, srst, writeInhibit, chip_select_strap, pending;
    logic scl, sdaCtl, sdaIn, sdaOut, sdaDriveN, standbyReg, progBusyReg;
    logic [7:0] mem [0:1023];
    logic [9:0] ctr, pg;
    logic [7:0] cutByte;
    int nMismatch = 0;
    int comparisons = 0;
    // Wired AND of both open-drain parties
    assign sdaIn = sdaCtl & (sdaDriveN | sdaOut);
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    ise_target #(.PROG_COUNT(PROG_N)) i_ise_target (.core_clk, .srst, .scl, .sdaIn, .sdaOut,
        .sdaDriveN, .writeInhibit, .chip_select_strap, .standbyReg, .progBusyReg);
    ise_ctrl_model i_ise_ctrl_model (.core_clk(core_clk), .sdaWire(sdaIn), .scl(scl),
        .sdaCtl(sdaCtl));
    task automatic check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            nMismatch++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask
    task automatic conclude();
        if (nMismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Device word with polling; retries only expected after a real write
    task automatic dev(input logic rd, input logic [9:0] a);
        logic ack;
        int tries;
        ack = 1'b0;
        tries = 0;
        while (!ack && tries < 40) begin
            i_ise_ctrl_model.start_cond();
            i_ise_ctrl_model.put_byte({DEV_PREAMBLE, chip_select_strap, a[9:8], rd}, ack);
            tries++;
        end
        check(ack, "device word refused");
        check(pending ? tries > 1 : tries == 1, "poll count");
        pending = 1'b0;
    endtask
    task automatic wr_seq(input logic [9:0] a, input int n);
        logic ack;
        logic [7:0] d;
        logic [3:0] ofs;
        dev(1'b0, a);
        i_ise_ctrl_model.put_byte(a[7:0], ack);
        check(ack, "word address nak");
        ofs = a[3:0];
        repeat (n) begin
            d = 8'($urandom);
            i_ise_ctrl_model.put_byte(d, ack);
            check(ack, "data nak");
            if (!writeInhibit) mem[{a[9:4], ofs}] = d;
            ofs++;
        end
        i_ise_ctrl_model.stop_cond();
        ctr = {a[9:4], ofs};
        pending = !writeInhibit;
    endtask
    task automatic rd_seq(input logic rnd, input logic [9:0] a, input int n);
        logic ack;
        logic [7:0] d;
        if (rnd) begin
            dev(1'b0, a);
            i_ise_ctrl_model.put_byte(a[7:0], ack);
            check(ack, "dummy address nak");
            ctr = a;
        end
        dev(1'b1, ctr);
        for (int i = 0; i < n; i++) begin
            i_ise_ctrl_model.get_byte(i < n - 1, d);
            check(d === mem[ctr], "read data");
            ctr++;
        end
        i_ise_ctrl_model.stop_cond();
        check(standbyReg === 1'b1, "no standby after read");
    endtask
    task automatic nak_case(input logic [7:0] dw);
        logic ack;
        i_ise_ctrl_model.start_cond();
        i_ise_ctrl_model.put_byte(dw, ack);
        check(ack === 1'b0, "foreign device word acked");
        i_ise_ctrl_model.stop_cond();
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        srst = 1'b1;
        writeInhibit = 1'b0;
        pending = 1'b0;
        void'($urandom(86644));
        chip_select_strap = 1'($urandom);
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        @(negedge core_clk);
        check(standbyReg === 1'b1 && sdaDriveN === 1'b1 && progBusyReg === 1'b0, "reset");
        repeat (4) @(negedge core_clk);
        pg = 10'($urandom);
        wr_seq(10'h000, 3);
        wr_seq(10'h3ff, 2);
        wr_seq(pg, 18);
        dev(1'b1, ctr);
        // Read cut after its first byte; nine released pulses free the bus
        i_ise_ctrl_model.recover(cutByte);
        check(cutByte === mem[ctr], "cut read data");
        rd_seq(1'b1, 10'h3ff, 3);
        rd_seq(1'b0, 10'h000, 1);
        i_ise_ctrl_model.slowLow = 6;
        rd_seq(1'b1, {pg[9:4], 4'h0}, 16);
        i_ise_ctrl_model.slowLow = 0;
        nak_case({4'h2, chip_select_strap, 3'h1});
        nak_case({4'hb, chip_select_strap, 3'h0});
        nak_case({DEV_PREAMBLE, ~chip_select_strap, 3'h1});
        writeInhibit = 1'b1;
        wr_seq({pg[9:4], 4'($urandom)}, 4);
        repeat (40) @(negedge core_clk);
        writeInhibit = 1'b0;
        rd_seq(1'b1, {pg[9:4], 4'h0}, 16);
        conclude();
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        nMismatch++;
        $display("unexpected at %0t: watchdog", $time);
        conclude();
    end
endmodule
bind ise_target ise_target_chk #(.PROG_COUNT(PROG_COUNT)) i_ise_target_chk (
    .core_clk(core_clk), .srst(srst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaDriveN(sdaDriveN), .writeInhibit(writeInhibit), .chip_select_strap(chip_select_strap),
    .standbyReg(standbyReg), .progBusyReg(progBusyReg));
`default_nettype wire
